// ===== tb/bgp_board_io_tb_top.sv
// Purpose: Self-checking bench for the board I/O and pin override block
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes: Pin reads wait three cycles so the input synchronisers settle
`timescale 1ns/1ns
`default_nettype none

module bgp_board_io_tb_top import bgp_pkg::*;;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [31:0] addr_in = 32'h0;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic user_clk_in = 1'b0;
    logic reset_button_in = 1'b0;
    logic [4:0] button_in = 5'h0;
    logic [7:0] dip_in = 8'h0;
    logic [1:0] coax_in = 2'h0;
    logic [5:0] ext_lvl = 6'h3F;
    logic [5:0] ctl_pin_o_in = 6'h0;
    logic [5:0] ctl_pin_oe_in = 6'h0;
    logic [31:0] rdata_out;
    logic [3:0] led_out;
    logic [4:0] dir_led_out;
    logic [1:0] coax_out;
    logic [1:0] bus_sel_out;
    logic [5:0] pin_in, pin_out, pin_oe_out;
    logic [5:0] ctl_pin_i_out;
    logic sys_reset_req_out;
    int n_fail = 0;
    int compares = 0;

    bgp_board_io dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
        .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .led_out(led_out),
        .dir_led_out(dir_led_out), .button_in(button_in), .dip_in(dip_in), .coax_in(coax_in),
        .coax_out(coax_out), .user_clk_in(user_clk_in), .bus_sel_out(bus_sel_out), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_out(pin_oe_out), .ctl_pin_o_in(ctl_pin_o_in),
        .ctl_pin_oe_in(ctl_pin_oe_in), .ctl_pin_i_out(ctl_pin_i_out), .reset_button_in(reset_button_in),
        .sys_reset_req_out(sys_reset_req_out));
    bgp_pin_model board_u (.drv_in(pin_out), .drv_oe_in(pin_oe_out), .ext_lvl_in(ext_lvl), .lvl_out(pin_in));

    // Free-running system clock
    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge sys_clk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge sys_clk_in);
        wr_in = 1'b0;
    endtask

    // Read after the synchronisers settle, then compare
    task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] e);
        repeat (3) @(negedge sys_clk_in);
        addr_in = a;
        rd_in = 1'b1;
        @(negedge sys_clk_in);
        rd_in = 1'b0;
        chk(name, rdata_out, e);
    endtask

    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end

    initial begin
        logic [31:0] exp;
        repeat (8) @(negedge sys_clk_in);
        rst_in = 1'b0;
        rchk("ctl reset", BGP_ADDR_CTL, BGP_CTL_RESET);
        chk("outs reset", 32'({led_out, dir_led_out, coax_out, bus_sel_out}), 32'h0);
        $display("test reset done");
        // All ones written; reserved and input bits must not stick
        button_in = 5'h15;
        dip_in = 8'hA5;
        coax_in = 2'h2;
        user_clk_in = 1'b1;
        wr(BGP_ADDR_DATA, 32'hFFFFFFFF);
        exp = 32'h1B0001FF | (32'h15 << 9) | (32'hA5 << 14) | (32'h2 << 22) | (32'h1 << 26);
        chk("leds", 32'({led_out, dir_led_out}), 32'h1FF);
        chk("coax bus_sel", 32'({coax_out, bus_sel_out}), 32'hF);
        rchk("data map", BGP_ADDR_DATA, exp);
        wr(32'h90000004, 32'h0);
        rchk("unmapped", 32'h90000004, 32'h0);
        rchk("data kept", BGP_ADDR_DATA, exp);
        $display("test data done");
        // Overrides off: controllers own the pins
        ctl_pin_o_in = 6'h15;
        ctl_pin_oe_in = 6'h2A;
        @(negedge sys_clk_in);
        chk("ctl pins", 32'({pin_oe_out, pin_out}), 32'hA95);
        rchk("pin off", BGP_ADDR_PIN, 32'h0);
        // Two-wire override, both directions output, then both input
        wr(BGP_ADDR_CTL, 32'h0F40);
        wr(BGP_ADDR_PIN, 32'h2);
        chk("tw drive", 32'({pin_oe_out, pin_out}), 32'hAD6);
        rchk("tw read", BGP_ADDR_PIN, 32'h2);
        ext_lvl = 6'h3D;
        wr(BGP_ADDR_CTL, 32'h0F43);
        chk("tw input", 32'(pin_oe_out), 32'h28);
        rchk("tw ext", BGP_ADDR_PIN, 32'h1);
        chk("ctl pins in", 32'(ctl_pin_i_out), 32'h15);
        $display("test two_wire done");
        // Keyboard/mouse override: mouse inputs, keyboard outputs
        wr(BGP_ADDR_CTL, 32'h0380);
        wr(BGP_ADDR_PIN, 32'h0403);
        chk("km oe", 32'(pin_oe_out), 32'h32);
        chk("kbd out", 32'(pin_out[5:4]), 32'h1);
        rchk("km read", BGP_ADDR_PIN, 32'h0700);
        $display("test kbd_mouse done");
        // Reset button with capture off, then on
        reset_button_in = 1'b1;
        for (int i = 0; i < 8 && sys_reset_req_out !== 1'b1; i++) @(negedge sys_clk_in);
        chk("reset req", 32'(sys_reset_req_out), 32'h1);
        rchk("btn hidden", BGP_ADDR_PIN, 32'h0700);
        reset_button_in = 1'b0;
        wr(BGP_ADDR_CTL, 32'h1F03);
        reset_button_in = 1'b1;
        rchk("btn read", BGP_ADDR_PIN, 32'h1000);
        chk("no reset", 32'(sys_reset_req_out), 32'h0);
        $display("test reset_button done");
        wrap_up();
    end
endmodule // bgp_board_io_tb_top

`default_nettype wire

// ===== tb/bgp_pin_model.sv
// Purpose: Board side of the six overridable pins
// Assumes: Every pin line carries a pull-up on the board
// Notes: A released line shows the outside driver or the pull-up level
`timescale 1ns/1ns
`default_nettype none

module bgp_pin_model (
    input wire logic [5:0] drv_in,
    input wire logic [5:0] drv_oe_in,
    input wire logic [5:0] ext_lvl_in,
    output logic [5:0] lvl_out
);
    // Driven bit wins; a released bit never keeps the last driven value
    assign lvl_out = (drv_oe_in & drv_in) | (~drv_oe_in & ext_lvl_in);
endmodule // bgp_pin_model

`default_nettype wire

// ===== verilog/bgp_board_io.sv
// Purpose: Board LED/button/switch register and direct pin override access
// Assumes: Simple register port, reads answered one cycle after the strobe
// Notes: Pin order 0..5 is two-wire clock, two-wire data, mouse clock,
//        mouse data, keyboard clock, keyboard data
`timescale 1ns/1ns
`default_nettype none

module bgp_board_io
    import bgp_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [31:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic [3:0] led_out,
    output logic [4:0] dir_led_out,
    input wire logic [4:0] button_in,
    input wire logic [7:0] dip_in,
    input wire logic [1:0] coax_in,
    output logic [1:0] coax_out,
    input wire logic user_clk_in,
    output logic [1:0] bus_sel_out,
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe_out,
    input wire logic [5:0] ctl_pin_o_in,
    input wire logic [5:0] ctl_pin_oe_in,
    output logic [5:0] ctl_pin_i_out,
    input wire logic reset_button_in,
    output logic sys_reset_req_out
);

    logic [31:0] data_reg;
    logic [31:0] pin_reg;
    logic [31:0] ctl_reg;
    logic [31:0] rdata_reg;
    logic [BGP_NSYNC-1:0] sync1_reg;
    logic [BGP_NSYNC-1:0] sync2_reg;
    logic [5:0] ctl_in_reg;
    logic rst_req_reg;
    logic [BGP_NSYNC-1:0] raw_in;
    logic sel_data;
    logic sel_pin;
    logic sel_ctl;
    logic [31:0] data_next;
    logic [31:0] pin_next;
    logic [31:0] ctl_next;
    logic [31:0] data_view;
    logic [31:0] pin_view;
    logic [31:0] rdata_next;
    logic [5:0] pin_ovr;
    logic [5:0] pin_live;
    bgp_pin_s [5:0] drive;

    // Address decode; unmapped addresses read zero and ignore writes
    assign sel_data = (addr_in == BGP_ADDR_DATA);
    assign sel_pin = (addr_in == BGP_ADDR_PIN);
    assign sel_ctl = (addr_in == BGP_ADDR_CTL);

    // Only writable bits are stored, so reserved bits stay zero
    assign data_next = wdata_in & BGP_DATA_WR_MASK;
    assign pin_next = wdata_in & BGP_PIN_WR_MASK;
    assign ctl_next = wdata_in & BGP_CTL_WR_MASK;

    // Every board input crosses into this clock through two flops
    assign raw_in = {reset_button_in, pin_in, user_clk_in, coax_in, dip_in, button_in};
    assign pin_live = sync2_reg[BGP_S_PIN +: 6];

    // Data register view: stored outputs merged with sampled inputs
    always_comb begin
        data_view = data_reg;
        data_view[BGP_BTN_LSB +: 5] = sync2_reg[BGP_S_BTN +: 5];
        data_view[BGP_DIP_LSB +: 8] = sync2_reg[BGP_S_DIP +: 8];
        data_view[BGP_COAX_IN_LSB +: 2] = sync2_reg[BGP_S_COAX +: 2];
        data_view[BGP_UCLK_BIT] = sync2_reg[BGP_S_UCLK];
    end

    // Override enable per pin: two two-wire pins, four keyboard/mouse pins
    assign pin_ovr = {{4{ctl_reg[BGP_KM_OVR_BIT]}}, {2{ctl_reg[BGP_TW_OVR_BIT]}}};

    // Per-pin override: mux, pin outputs and assertions
    genvar g;
    generate
        for (g = 0; g < BGP_NPIN; g = g + 1) begin : g_pin
            // Direction 0 drives the latched value, 1 only listens
            assign drive[g].oe = pin_ovr[g] ? ~ctl_reg[BGP_PIN_BIT[g]] : ctl_pin_oe_in[g];
            assign drive[g].o = pin_ovr[g] ? pin_reg[BGP_PIN_BIT[g]] : ctl_pin_o_in[g];
            assign pin_out[g] = drive[g].o;
            assign pin_oe_out[g] = drive[g].oe;

            a_pin_drive_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
                (pin_ovr[g] && !ctl_reg[BGP_PIN_BIT[g]]) |-> (pin_oe_out[g] && pin_out[g] == pin_reg[BGP_PIN_BIT[g]]))
                else $error("override pin not driven from written value");
            a_pin_dir_input: assert property (@(posedge sys_clk_in) disable iff (rst_in)
                (pin_ovr[g] && ctl_reg[BGP_PIN_BIT[g]]) |-> !pin_oe_out[g])
                else $error("input-direction pin is driven");
            a_pin_ctl_return: assert property (@(posedge sys_clk_in) disable iff (rst_in)
                !pin_ovr[g] |-> (pin_oe_out[g] == ctl_pin_oe_in[g] && pin_out[g] == ctl_pin_o_in[g]))
                else $error("pin not returned to its controller");
        end
    endgenerate

    // Pin-access view: live pin values only while enabled
    always_comb begin
        pin_view = 32'h0000_0000;
        for (int i = 0; i < BGP_NPIN; i++) begin
            pin_view[BGP_PIN_BIT[i]] = pin_ovr[i] & pin_live[i];
        end
        pin_view[BGP_RST_BTN_BIT] = ctl_reg[BGP_RST_CAP_BIT] & sync2_reg[BGP_S_RST];
    end

    // Read mux
    assign rdata_next = sel_data ? data_view : sel_pin ? pin_view : sel_ctl ? ctl_reg : 32'h0000_0000;

    // Input synchronisers
    always_ff @(posedge sys_clk_in) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
    end

    // Register writes
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            data_reg <= BGP_DATA_RESET;
            pin_reg <= BGP_PIN_RESET;
            ctl_reg <= BGP_CTL_RESET;
        end else if (wr_in) begin
            if (sel_data) data_reg <= data_next;
            if (sel_pin) pin_reg <= pin_next;
            if (sel_ctl) ctl_reg <= ctl_next;
        end
    end

    // Read data, reset request, controller-side pin values
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h0000_0000;
            rst_req_reg <= 1'b0;
            ctl_in_reg <= 6'h00;
        end else begin
            if (rd_in) rdata_reg <= rdata_next;
            // Captured button is masked so software can poll it safely
            rst_req_reg <= sync2_reg[BGP_S_RST] & ~ctl_reg[BGP_RST_CAP_BIT];
            ctl_in_reg <= pin_live;
        end
    end

    // Board outputs straight from the data register; read data, reset request and pin copy from their registers
    assign led_out = data_reg[BGP_LED_LSB +: 4];
    assign dir_led_out = data_reg[BGP_DLED_LSB +: 5];
    assign coax_out = data_reg[BGP_COAX_OUT_LSB +: 2];
    assign bus_sel_out = data_reg[BGP_BSEL_LSB +: 2];
    assign rdata_out = rdata_reg;
    assign sys_reset_req_out = rst_req_reg;
    assign ctl_pin_i_out = ctl_in_reg;

    a_led_write_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (wr_in && sel_data) |=> ({dir_led_out, led_out} == $past(wdata_in[8:0])))
        else $error("LED outputs do not follow write");
    a_button_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_data) |=> (rdata_out[13:9] == $past(sync2_reg[4:0])))
        else $error("button bits wrong on read");
    a_dip_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_data) |=> (rdata_out[21:14] == $past(sync2_reg[12:5])))
        else $error("switch bits wrong on read");
    // Coax inputs sit at 23:22 and the user clock at 26; stored coax outputs between them
    a_coax_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_data) |=> ({rdata_out[26], rdata_out[23:22]} == $past(sync2_reg[15:13])))
        else $error("coax or user clock bits wrong");
    a_coax_out_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_data) |=> (rdata_out[25:24] == $past(coax_out)))
        else $error("coax output bits not read back");
    a_rsvd_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_data) |=> (rdata_out[31:29] == 3'h0))
        else $error("reserved bits not zero");
    a_bus_sel_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (wr_in && sel_data) |=> (bus_sel_out == $past(wdata_in[28:27])))
        else $error("bus select does not follow write");
    a_tw_gate_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_pin && !ctl_reg[BGP_TW_OVR_BIT]) |=> (rdata_out[1:0] == 2'h0))
        else $error("two-wire bits visible while disabled");
    a_km_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_pin && ctl_reg[BGP_KM_OVR_BIT]) |=> (rdata_out[11:8] == $past(sync2_reg[21:18])))
        else $error("keyboard/mouse pins not read live");
    a_rst_btn_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_pin) |=> (rdata_out[12] == $past(ctl_reg[12] & sync2_reg[22])))
        else $error("reset button bit wrong");
    a_rst_blocked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (ctl_reg[BGP_RST_CAP_BIT] && $past(ctl_reg[BGP_RST_CAP_BIT])) |-> !sys_reset_req_out)
        else $error("captured reset button caused reset");

    // Pin-access gaps and the controller-side copy of the pins
    a_pin_rsvd_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_pin) |=> (rdata_out[31:13] == 19'h00000 && rdata_out[7:2] == 6'h00))
        else $error("pin-access reserved bits not zero");
    a_km_gate_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_in && sel_pin && !ctl_reg[BGP_KM_OVR_BIT]) |=> (rdata_out[11:8] == 4'h0))
        else $error("keyboard/mouse bits visible while disabled");
    a_ctl_pin_in: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        1'b1 |=> (ctl_pin_i_out == $past(pin_live)))
        else $error("controller pin copy does not follow pins");

endmodule // bgp_board_io

`default_nettype wire

// ===== verilog/bgp_pkg.sv
// Purpose: Constants and types for the board I/O and pin override block
// Assumes: One 50 MHz clock, synchronous active-high reset
// Notes: Register addresses are full 32-bit byte addresses
package bgp_pkg;

    // Register addresses
    localparam logic [31:0] BGP_ADDR_DATA = 32'h0900_0000;
    localparam logic [31:0] BGP_ADDR_PIN = 32'h9000_0008;
    localparam logic [31:0] BGP_ADDR_CTL = 32'h9000_000C;

    // Board I/O data register fields
    localparam int BGP_LED_LSB = 0;
    localparam int BGP_DLED_LSB = 4;
    localparam int BGP_BTN_LSB = 9;
    localparam int BGP_DIP_LSB = 14;
    localparam int BGP_COAX_IN_LSB = 22;
    localparam int BGP_COAX_OUT_LSB = 24;
    localparam int BGP_UCLK_BIT = 26;
    localparam int BGP_BSEL_LSB = 27;

    // Companion control register fields
    localparam int BGP_TW_OVR_BIT = 6;
    localparam int BGP_KM_OVR_BIT = 7;
    localparam int BGP_RST_CAP_BIT = 12;

    // Pin-access register: reset button bit; overridable pin bit positions
    localparam int BGP_RST_BTN_BIT = 12;
    localparam int BGP_NPIN = 6;
    localparam int BGP_PIN_BIT [BGP_NPIN] = '{0, 1, 8, 9, 10, 11};

    // Writable bit masks; all other bits are inputs or reserved
    localparam logic [31:0] BGP_DATA_WR_MASK = 32'h1B00_01FF;
    localparam logic [31:0] BGP_PIN_WR_MASK = 32'h0000_0F03;
    localparam logic [31:0] BGP_CTL_WR_MASK = 32'h0000_1FC3;

    // Values after reset: outputs off, every pin direction an input
    localparam logic [31:0] BGP_DATA_RESET = 32'h0000_0000;
    localparam logic [31:0] BGP_PIN_RESET = 32'h0000_0000;
    localparam logic [31:0] BGP_CTL_RESET = 32'h0000_0F03;

    // Synchroniser vector layout
    localparam int BGP_S_BTN = 0;
    localparam int BGP_S_DIP = 5;
    localparam int BGP_S_COAX = 13;
    localparam int BGP_S_UCLK = 15;
    localparam int BGP_S_PIN = 16;
    localparam int BGP_S_RST = 22;
    localparam int BGP_NSYNC = 23;

    // One driven pin
    typedef struct packed {
        logic o;
        logic oe;
    } bgp_pin_s;

endpackage
